//--- rhsp_host.sv
/*
 * Host end: SPI mode-0 master that clocks one full-duplex byte per request.
 * Holds select low across the bytes of one access until a byte marked last ends.
 */
`timescale 1ns/1ps
`default_nettype none
module rhsp_host (
    input wire logic CLK,
    input wire logic RST_N,
    rhsp_if.host LINK,
    input wire logic XFER_START,
    input wire logic [7:0] XFER_DATA,
    input wire logic XFER_LAST,
    output logic XFER_BUSY,
    output logic [7:0] XFER_RX,
    output logic XFER_DONE,
    input wire logic RADIO_RESET,
    input wire logic CTL_LEVEL,
    output logic IRQ_SEEN
);
    typedef enum logic [1:0] {RHSP_IDLE, RHSP_LOW, RHSP_HIGH, RHSP_TAIL} rhsp_state_t;
    rhsp_state_t state;
    logic [3:0] half_cnt;
    logic [2:0] bit_cnt;
    logic [7:0] tx;
    logic [7:0] rx;
    logic last;
    logic sel_n;
    logic sclk;
    logic miso_s;
    logic irq_s;

    // The radio leaves its data line floating when deselected; a pull-up keeps it defined.
    wire miso_pin = LINK.miso_oe ? LINK.miso : 1'b1;

    rhsp_sync #(.INIT(1'b1)) u_miso (.CLK(CLK), .RST_N(RST_N), .d(miso_pin), .q(miso_s));
    rhsp_sync #(.INIT(1'b0)) u_irq (.CLK(CLK), .RST_N(RST_N), .d(LINK.irq), .q(irq_s));

    wire half_done = half_cnt == 4'(rhsp_pkg::SCK_HALF_CYCLES - 1);

    // ------------------------------------------------------------------
    // Byte engine
    // ------------------------------------------------------------------
    // Every byte sent also returns one, so a read is just a dummy write.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state <= RHSP_IDLE;
            half_cnt <= 4'h0;
            bit_cnt <= 3'h0;
            tx <= 8'h00;
            rx <= 8'h00;
            last <= 1'b0;
            sel_n <= 1'b1;
            sclk <= 1'b0;
            XFER_BUSY <= 1'b0;
            XFER_DONE <= 1'b0;
            XFER_RX <= 8'h00;
        end else begin
            XFER_DONE <= 1'b0;
            half_cnt <= half_done ? 4'h0 : half_cnt + 4'h1;
            unique case (state)
                RHSP_IDLE: begin
                    half_cnt <= 4'h0;
                    if (XFER_START) begin
                        tx <= XFER_DATA;
                        last <= XFER_LAST;
                        sel_n <= 1'b0;
                        bit_cnt <= 3'h0;
                        XFER_BUSY <= 1'b1;
                        state <= RHSP_LOW;
                    end
                end
                RHSP_LOW: if (half_done) begin
                    sclk <= 1'b1;
                    state <= RHSP_HIGH;
                end
                RHSP_HIGH: if (half_done) begin
                    // Sample just before the falling edge, well past the synchroniser delay.
                    rx <= {rx[6:0], miso_s};
                    sclk <= 1'b0;
                    tx <= {tx[6:0], 1'b0};
                    bit_cnt <= bit_cnt + 3'h1;
                    state <= (bit_cnt == 3'h7) ? RHSP_TAIL : RHSP_LOW;
                end
                RHSP_TAIL: if (half_done) begin
                    XFER_RX <= rx;
                    XFER_DONE <= 1'b1;
                    XFER_BUSY <= 1'b0;
                    sel_n <= !last ? 1'b0 : 1'b1;
                    state <= RHSP_IDLE;
                end
            endcase
        end
    end

    // Interrupt is registered after its synchroniser; reset and control pins pass straight through; clock output is left unused by this host.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            IRQ_SEEN <= 1'b0;
        end else begin
            IRQ_SEEN <= irq_s;
        end
    end

    assign LINK.sel_n = sel_n;
    assign LINK.sclk = sclk;
    assign LINK.mosi = tx[7];
    assign LINK.rst_n_pin = !RADIO_RESET;
    assign LINK.sleep_txstart_ctl = CTL_LEVEL;
endmodule
`default_nettype wire

//--- rhsp_if.sv
/*
 * Interface joining the host end and the radio end of the serial port.
 * Assumes the host end resolves the shared data-out line from its enable.
 */
`timescale 1ns/1ps
`default_nettype none
interface rhsp_if;
    logic sel_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic rst_n_pin;
    logic irq;
    logic host_clock_out;
    logic sleep_txstart_ctl;

    // ------------------------------------------------------------------
    // Views
    // ------------------------------------------------------------------
    modport radio (input sel_n, input sclk, input mosi, output miso, output miso_oe,
        input rst_n_pin, output irq, output host_clock_out, input sleep_txstart_ctl);
    modport host (output sel_n, output sclk, output mosi, input miso, input miso_oe,
        output rst_n_pin, input irq, input host_clock_out, output sleep_txstart_ctl);
endinterface
`default_nettype wire

//--- rhsp_monitor.sv
/*
 * Checker for the link between the host end and the radio end.
 * Assumes both ends share CLK and that it sees the link signals only.
 */
`timescale 1ns/1ps
`default_nettype none
module rhsp_monitor (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso_oe,
    input wire logic rst_n_pin,
    input wire logic irq,
    input wire logic host_clock_out
);
    // ------------------------
    // Helper logic
    // ------------------------
    // Clock rises in one select window, modulo eight, so a short byte shows.
    logic sclk_q;
    logic [2:0] rises;
    always_ff @(posedge CLK) begin
        sclk_q <= sclk;
        if (!RST_N || sel_n) begin
            rises <= 3'h0;
        end else if (sclk && !sclk_q) begin
            rises <= rises + 3'h1;
        end
    end

    // ------------------------
    // Properties
    // ------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Opening a frame is select falling while the clock stays parked low.
    sequence s_open;
        $fell(sel_n);
    endsequence
    sequence s_parked;
        !sclk ##1 !sclk;
    endsequence
    a_open_clock_parked: assert property (s_open |-> s_parked)
        else $error("clock not parked low at select");
    a_idle_clock_low: assert property (sel_n |-> !sclk)
        else $error("clock moved while deselected");
    a_whole_bytes: assert property ($rose(sel_n) |-> rises == 3'h0)
        else $error("frame closed inside a byte");
    a_mosi_held: assert property ($rose(sclk) |=> $stable(mosi))
        else $error("data in changed at sampling edge");
    a_drive_on_select: assert property (s_open |-> ##[1:6] miso_oe)
        else $error("data out not driven after select");
    a_float_when_idle: assert property (sel_n [*6] |-> !miso_oe)
        else $error("data out driven while deselected");
    a_drive_in_reset: assert property ((!sel_n && !rst_n_pin) [*6] |-> miso_oe)
        else $error("data out off with select and reset low");
    a_clock_out_runs: assert property (rst_n_pin [*8] |-> host_clock_out != $past(host_clock_out))
        else $error("clock output stalled");
    a_irq_in_reset: assert property ((!rst_n_pin) [*6] |-> !irq)
        else $error("interrupt raised while held in reset");
    c_open: cover property (s_open);
endmodule
`default_nettype wire

//--- rhsp_pkg.sv
/*
 * Shared constants for the radio host serial port: framing, command byte
 * layout, clock dividers and pin synchroniser depth.
 * Assumes both ends run on their own 25 MHz clock with a synchronous reset.
 */
package rhsp_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int SYS_CLK_HZ = 25000000;
    localparam int SCK_MAX_SYNC_HZ = 8000000;
    localparam int SCK_MAX_ASYNC_HZ = 7500000;
    // Half period of the host serial clock. The round trip from a host clock edge through both
    // pin filters and back is about eleven cycles, so two half periods must cover it; six gives
    // roughly 2 MHz, well under both the sync and async limits.
    localparam int SCK_HALF_CYCLES = 6;
    localparam int CLKOUT_HALF_CYCLES = 1;
    localparam int BITS_PER_BYTE = 8;
    localparam int SYNC_DEPTH = 3;
    // ------------------------------------------------------------------
    // Command byte layout
    // ------------------------------------------------------------------
    localparam int CMD_KIND_BIT = 7;
    localparam int CMD_WRITE_BIT = 6;
    localparam int CMD_FB_BIT = 5;
    localparam int CMD_ADDR_MSB = 5;
    localparam logic [7:0] MISO_IDLE_BYTE = 8'h00;
    localparam logic [7:0] RESET_REG_VALUE = 8'h00;
endpackage

//--- rhsp_radio.sv
/*
 * Radio end of the serial port: mode-0 slave shifter, command decode,
 * a small register array, a clock output and the side-band pins.
 * Assumes the host is the only master and obeys the serial clock limits.
 */
`timescale 1ns/1ps
`default_nettype none
module rhsp_radio (
    input wire logic CLK,
    input wire logic RST_N,
    rhsp_if.radio LINK,
    output logic [7:0] RX_BYTE,
    output logic RX_VALID,
    output logic [7:0] CMD_BYTE,
    output logic CMD_VALID,
    output logic ACCESS_DONE,
    output logic SLEEP_REQ,
    input wire logic [7:0] FB_DATA,
    input wire logic EVENT_IN
);
    logic sel_n_s;
    logic sclk_s;
    logic mosi_s;
    logic ctl_s;
    logic rst_pin_s;
    logic sclk_d;
    logic sel_d;
    logic [2:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic first_byte;
    logic [7:0] cmd;
    logic [7:0] regs [0:63];
    logic [1:0] clk_div;
    logic miso;
    logic miso_oe;
    logic irq;
    logic clk_out;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    rhsp_sync #(.INIT(1'b1)) u_sel (.CLK(CLK), .RST_N(RST_N), .d(LINK.sel_n), .q(sel_n_s));
    rhsp_sync #(.INIT(1'b0)) u_sck (.CLK(CLK), .RST_N(RST_N), .d(LINK.sclk), .q(sclk_s));
    rhsp_sync #(.INIT(1'b0)) u_mosi (.CLK(CLK), .RST_N(RST_N), .d(LINK.mosi), .q(mosi_s));
    rhsp_sync #(.INIT(1'b0)) u_ctl (.CLK(CLK), .RST_N(RST_N), .d(LINK.sleep_txstart_ctl), .q(ctl_s));
    rhsp_sync #(.INIT(1'b1)) u_rst (.CLK(CLK), .RST_N(RST_N), .d(LINK.rst_n_pin), .q(rst_pin_s));

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire active = !sel_n_s;
    wire sck_rise = active && sclk_s && !sclk_d;
    wire sck_fall = active && !sclk_s && sclk_d;
    wire sel_fall = !sel_n_s && sel_d;
    wire sel_rise = sel_n_s && !sel_d;
    wire byte_end = sck_rise && (bit_cnt == 3'(rhsp_pkg::BITS_PER_BYTE - 1));
    wire [7:0] rx_next = {shift_in[6:0], mosi_s};
    wire is_reg = cmd[rhsp_pkg::CMD_KIND_BIT];
    wire is_write = cmd[rhsp_pkg::CMD_WRITE_BIT];
    wire [5:0] reg_addr = cmd[rhsp_pkg::CMD_ADDR_MSB:0];
    wire [5:0] rx_addr = rx_next[rhsp_pkg::CMD_ADDR_MSB:0];
    // Reply byte for the second slot: register contents on any register command, read or write, else frame data.
    wire [7:0] reply = (first_byte && rx_next[rhsp_pkg::CMD_KIND_BIT]) ? regs[rx_addr] : FB_DATA;

    // ------------------------------------------------------------------
    // Shifter
    // ------------------------------------------------------------------
    // Edges are tracked from filtered copies so a glitch on a pin caught by one sample only never counts.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sclk_d <= 1'b0;
            sel_d <= 1'b1;
            bit_cnt <= 3'h0;
            shift_in <= 8'h00;
            shift_out <= rhsp_pkg::MISO_IDLE_BYTE;
            first_byte <= 1'b1;
            cmd <= 8'h00;
            RX_VALID <= 1'b0;
            CMD_VALID <= 1'b0;
            RX_BYTE <= 8'h00;
            CMD_BYTE <= 8'h00;
            ACCESS_DONE <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
            sel_d <= sel_n_s;
            RX_VALID <= 1'b0;
            CMD_VALID <= 1'b0;
            ACCESS_DONE <= sel_rise;
            if (sel_fall) begin
                bit_cnt <= 3'h0;
                first_byte <= 1'b1;
                shift_out <= rhsp_pkg::MISO_IDLE_BYTE;
            end else if (sck_rise) begin
                bit_cnt <= bit_cnt + 3'h1;
                shift_in <= rx_next;
                if (byte_end) begin
                    RX_BYTE <= rx_next;
                    RX_VALID <= 1'b1;
                    first_byte <= 1'b0;
                    shift_out <= reply;
                    if (first_byte) begin
                        cmd <= rx_next;
                        CMD_BYTE <= rx_next;
                        CMD_VALID <= 1'b1;
                    end
                end
            end else if (sck_fall && bit_cnt != 3'h0) begin
                shift_out <= {shift_out[6:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------------
    // Register array
    // ------------------------------------------------------------------
    // Every byte after the command of a register write lands at the same address; the last one stays.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            for (int i = 0; i < 64; i++) begin
                regs[i] <= rhsp_pkg::RESET_REG_VALUE;
            end
        end else if (byte_end && !first_byte && is_reg && is_write && bit_cnt == 3'h7) begin
            regs[reg_addr] <= rx_next;
        end
    end

    // ------------------------------------------------------------------
    // Pins out
    // ------------------------------------------------------------------
    // The data line is enabled by select alone, reset pin state included.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            miso <= 1'b0;
            miso_oe <= 1'b0;
            irq <= 1'b0;
            clk_div <= 2'h0;
            clk_out <= 1'b0;
            SLEEP_REQ <= 1'b0;
        end else begin
            miso <= shift_out[7];
            miso_oe <= !sel_n_s;
            irq <= EVENT_IN && rst_pin_s;
            SLEEP_REQ <= ctl_s;
            if (clk_div == 2'(rhsp_pkg::CLKOUT_HALF_CYCLES - 1)) begin
                clk_div <= 2'h0;
                clk_out <= !clk_out && rst_pin_s;
            end else begin
                clk_div <= clk_div + 2'h1;
            end
        end
    end

    assign LINK.miso = miso;
    assign LINK.miso_oe = miso_oe;
    assign LINK.irq = irq;
    assign LINK.host_clock_out = clk_out;
endmodule
`default_nettype wire

//--- rhsp_sync.sv
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes the input is asynchronous to CLK.
 */
`timescale 1ns/1ps
`default_nettype none
module rhsp_sync #(
    parameter logic INIT = 1'b0
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic d,
    output logic q
);
    logic [2:0] stage;

    // ------------------------------------------------------------------
    // Chain
    // ------------------------------------------------------------------
    // The output moves only when the second and third stages agree.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            stage <= {3{INIT}};
            q <= INIT;
        end else begin
            stage <= {stage[1:0], d};
            if (stage[1] == stage[2]) begin
                q <= stage[2];
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench.sv
/*
 * Self-checking bench: host end and radio end joined by the link.
 * Assumes one 25 MHz clock for both ends; inputs move 1 ns after edges.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ------------------------
    // Harness
    // ------------------------
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic XFER_START = 1'b0;
    logic [7:0] XFER_DATA = 8'h00;
    logic XFER_LAST = 1'b0;
    logic RADIO_RESET = 1'b0;
    logic CTL_LEVEL = 1'b0;
    logic [7:0] FB_DATA = 8'h00;
    logic EVENT_IN = 1'b0;
    logic XFER_BUSY, XFER_DONE, IRQ_SEEN, RX_VALID, CMD_VALID, ACCESS_DONE, SLEEP_REQ;
    logic [7:0] XFER_RX, RX_BYTE, CMD_BYTE;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    int n_rx = 0;
    int n_cmd = 0;
    rhsp_if LINK ();
    rhsp_radio i_rhsp_radio (.CLK, .RST_N, .LINK, .RX_BYTE, .RX_VALID, .CMD_BYTE, .CMD_VALID,
        .ACCESS_DONE, .SLEEP_REQ, .FB_DATA, .EVENT_IN);
    rhsp_host i_rhsp_host (.CLK, .RST_N, .LINK, .XFER_START, .XFER_DATA, .XFER_LAST, .XFER_BUSY,
        .XFER_RX, .XFER_DONE, .RADIO_RESET, .CTL_LEVEL, .IRQ_SEEN);
    rhsp_monitor i_rhsp_monitor (.CLK(CLK), .RST_N(RST_N), .sel_n(LINK.sel_n), .sclk(LINK.sclk),
        .mosi(LINK.mosi), .miso_oe(LINK.miso_oe), .rst_n_pin(LINK.rst_n_pin), .irq(LINK.irq),
        .host_clock_out(LINK.host_clock_out));

    // Clock, and a cycle ceiling well above the roughly 3000 cycles needed.
    always #20 CLK = ~CLK;
    // Byte and command strobes are counted off the falling edge, where they are settled.
    always @(negedge CLK) begin
        if (RX_VALID === 1'b1) n_rx++;
        if (CMD_VALID === 1'b1) n_cmd++;
    end
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 10000) begin
            n_mismatch++;
            close_out();
        end
    end

    // ------------------------
    // Tasks
    // ------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    // Bounded wait on a level, then judged, so a hang shows as a mismatch.
    task automatic wait_on(ref logic s, input logic v, input int lim, input string what);
        int k;
        k = 0;
        while (s !== v && k < lim) begin
            tick(1);
            k++;
        end
        chk(what, {7'h0, s}, {7'h0, v});
    endtask
    // One full-duplex byte; the request is held until the next edge takes it.
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] rx);
        XFER_DATA = d;
        XFER_LAST = last;
        XFER_START = 1'b1;
        tick(1);
        XFER_START = 1'b0;
        chk("busy", {7'h0, XFER_BUSY}, 8'h01);
        wait_on(XFER_DONE, 1'b1, 200, "byte done");
        rx = XFER_RX;
    endtask
    // Command byte then n data bytes d, d+1, ...; replies judged when asked.
    task automatic run(input logic [7:0] cmd, input int n, input logic [7:0] d, input bit judge,
        input logic [7:0] exp);
        logic [7:0] rx;
        int rx0;
        int cmd0;
        rx0 = n_rx;
        cmd0 = n_cmd;
        xfer(cmd, 1'b0, rx);
        for (int i = 0; i < n; i++) begin
            xfer(d + 8'(i), i == n - 1, rx);
            if (judge) chk("reply", rx, exp);
        end
        wait_on(ACCESS_DONE, 1'b1, 40, "access closed");
        tick(2);
        chk("command", CMD_BYTE, cmd);
        chk("last byte", RX_BYTE, d + 8'(n - 1));
        chk("bytes seen", 8'(n_rx - rx0), 8'(n + 1));
        chk("commands seen", 8'(n_cmd - cmd0), 8'h01);
    endtask
    task automatic test_registers();
        run(8'hc5, 1, 8'ha5, 1'b0, 8'h00);
        run(8'hff, 1, 8'h5a, 1'b0, 8'h00);
        run(8'h85, 1, 8'h00, 1'b1, 8'ha5);
        run(8'hbf, 1, 8'h00, 1'b1, 8'h5a);
        run(8'hbe, 1, 8'h00, 1'b1, rhsp_pkg::RESET_REG_VALUE);
        $display("test_registers done");
    endtask
    // Every buffer and memory mode, four bytes each, replies from the buffer.
    task automatic test_buffers();
        logic [7:0] cmds [4] = '{8'h20, 8'h60, 8'h00, 8'h40};
        for (int i = 0; i < 4; i++) begin
            FB_DATA = 8'h3c ^ cmds[i];
            run(cmds[i], 3, 8'h10, 1'b1, 8'h3c ^ cmds[i]);
        end
        $display("test_buffers done");
    endtask
    task automatic test_sideband();
        CTL_LEVEL = 1'b1;
        wait_on(SLEEP_REQ, 1'b1, 10, "control in");
        EVENT_IN = 1'b1;
        wait_on(IRQ_SEEN, 1'b1, 20, "irq raised");
        RADIO_RESET = 1'b1;
        wait_on(IRQ_SEEN, 1'b0, 20, "irq in reset");
        FB_DATA = 8'h96;
        run(8'h20, 1, 8'h33, 1'b1, 8'h96);
        RADIO_RESET = 1'b0;
        CTL_LEVEL = 1'b0;
        wait_on(IRQ_SEEN, 1'b1, 20, "irq back");
        wait_on(SLEEP_REQ, 1'b0, 10, "control out");
        EVENT_IN = 1'b0;
        wait_on(IRQ_SEEN, 1'b0, 20, "irq clear");
        $display("test_sideband done");
    endtask

    // ------------------------
    // Main sequence
    // ------------------------
    // Reset covers the pin filters' flush before the first request.
    initial begin
        tick(4);
        RST_N = 1'b1;
        tick(4);
        test_registers();
        test_buffers();
        test_sideband();
        close_out();
    end
endmodule
`default_nettype wire
